// >>> src/memory_bus_pointer_port.sv
// Purpose: memory bus master port shared by the access sites of one address space
// Assumes: memory side and sites run on hclk; control over AHB-Lite
// Notes:   one instance per address space identifier
//
// Contract
// - data width power of two, 8..1024, default 64
// - address width 1..64, default 64
// - base pointer is always 64 bits wide
// - each address space gets its own bus
// - same-space sites arbitrated onto one bus
// - fixed latency default 1; zero means variable
// - max burst 1..1024 sizes the burstcount
// - fixed latency forces single-transfer bursts
// - site width is element size, base aligned
// - alignment bounds bytes coalesced per word
// - direction read-write, read-only or write-only
// - optional waitrequest input stalls requests
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module memory_bus_pointer_port #(
    parameter int                        DWIDTH    = mm_port_pkg::DWIDTH_DEF,
    parameter int                        AWIDTH    = mm_port_pkg::AWIDTH_DEF,
    parameter int                        ASPACE    = mm_port_pkg::ASPACE_DEF,
    parameter int                        LATENCY   = mm_port_pkg::LATENCY_DEF,
    parameter int                        MAXBURST  = mm_port_pkg::MAXBURST_DEF,
    parameter int                        ALIGN     = DWIDTH / 8,
    parameter mm_port_pkg::rw_mode_t     MODE      = mm_port_pkg::MODE_READWRITE,
    parameter bit                        WAITREQ   = 1'b0,
    parameter int                        SITES     = mm_port_pkg::SITES_DEF,
    parameter int                        TAG_DEPTH = mm_port_pkg::TAG_DEPTH_DEF,
    parameter int                        IDXW      = (SITES > 1) ? $clog2(SITES) : 1,
    parameter int                        BCW       = $clog2(MAXBURST) + 1
) (
    input  wire logic                                    hclk,
    input  wire logic                                    hresetn,
    // control bus
    input  wire logic                                    hsel,
    input  wire logic [31:0]                             haddr,
    input  wire logic [1:0]                              htrans,
    input  wire logic                                    hwrite,
    input  wire logic [2:0]                              hsize,
    input  wire logic [31:0]                             hwdata,
    input  wire logic                                    hready,
    output logic                                         hreadyout,
    output logic      [31:0]                             hrdata,
    output logic                                         hresp,
    // access sites
    input  wire logic [SITES-1:0]                        site_req,
    input  wire logic [SITES-1:0]                        site_wr,
    input  wire logic [SITES-1:0][mm_port_pkg::PTR_W-1:0] site_offset,
    input  wire logic [SITES-1:0][DWIDTH-1:0]            site_wdata,
    input  wire logic [SITES-1:0][DWIDTH/8-1:0]          site_be,
    input  wire logic [SITES-1:0][BCW-1:0]               site_burst,
    output logic      [SITES-1:0]                        site_gnt,
    output logic                                         rsp_valid,
    output logic      [IDXW-1:0]                         rsp_site,
    output logic                                         rsp_last,
    output logic      [DWIDTH-1:0]                       rsp_data,
    // memory bus
    output logic      [AWIDTH-1:0]                       mm_address,
    output logic                                         mm_read,
    output logic                                         mm_write,
    output logic      [DWIDTH-1:0]                       mm_writedata,
    output logic      [DWIDTH/8-1:0]                     mm_byteenable,
    output logic      [BCW-1:0]                          mm_burstcount,
    input  wire logic [DWIDTH-1:0]                       mm_readdata,
    input  wire logic                                    mm_readdatavalid,
    input  wire logic                                    mm_waitrequest
);
    // ****************************************
    // derived build settings
    // ****************************************
    localparam int  BEW      = DWIDTH / 8;
    localparam int  MAXB_EFF = (LATENCY != 0) ? 1 : MAXBURST;
    localparam int  LP       = (LATENCY > 0) ? LATENCY : 1;
    localparam int  TW       = IDXW + BCW;
    localparam int  TCW      = $clog2(TAG_DEPTH + 1);
    localparam bit  CAN_RD   = (MODE != mm_port_pkg::MODE_WRITEONLY);
    localparam bit  CAN_WR   = (MODE != mm_port_pkg::MODE_READONLY);
    localparam logic [AWIDTH-1:0] WORD_MASK = ~(AWIDTH'(BEW - 1));

    // an illegal build setting leaves the port idle: no site is ever granted
    localparam bit  CFG_OK   = DWIDTH >= 8 && DWIDTH <= 1024 &&
                               (DWIDTH & (DWIDTH - 1)) == 0 &&
                               AWIDTH >= 1 && AWIDTH <= 64 &&
                               MAXBURST >= 1 && MAXBURST <= mm_port_pkg::MAXBURST_MAX &&
                               ASPACE >= 1;

    // ****************************************
    // control registers
    // ****************************************
    logic                          en_r;
    logic [mm_port_pkg::PTR_W-1:0] base_r;
    logic [31:0]                   rd_cnt_r;
    logic [31:0]                   wr_cnt_r;
    logic                          dp_rd_r;
    logic                          dp_wr_r;
    logic                          rd_done_r;
    logic [mm_port_pkg::OFS_W-1:0] dp_addr_r;
    logic [31:0]                   hrdata_r;
    logic [31:0]                   reg_mux;
    logic [31:0]                   status_word;
    logic [31:0]                   config_word;
    logic                          ap_valid;
    logic                          wr_commit;
    logic                          clr_cnt;

    // command stage and read tracking
    logic                    cmd_valid_r;
    logic                    cmd_wr_r;
    logic [AWIDTH-1:0]       cmd_addr_r;
    logic [BEW-1:0]          cmd_be_r;
    logic [DWIDTH-1:0]       cmd_data_r;
    logic [BCW-1:0]          cmd_burst_r;
    logic [BCW-1:0]          wbeats_r;
    logic [BCW-1:0]          rbeat_r;
    logic [LP-1:0]           lat_pipe_r;
    logic                    rsp_valid_r;
    logic [IDXW-1:0]         rsp_site_r;
    logic                    rsp_last_r;
    logic [DWIDTH-1:0]       rsp_data_r;
    logic [IDXW-1:0]         sel;
    logic                    sel_wr;
    logic                    sel_ok;
    logic                    in_burst;
    logic                    stall;
    logic                    take;
    logic                    issue;
    logic                    tag_full;
    logic [TW-1:0]           tag_head;
    logic [TCW-1:0]          tag_count;
    logic                    beat_valid;
    logic                    beat_last;
    logic [BCW-1:0]          sel_burst;
    logic [mm_port_pkg::PTR_W-1:0] addr_full;
    logic [BEW-1:0]          coal_mask;

    // ****************************************
    // AHB-Lite slave, reads take one wait state
    // ****************************************
    assign ap_valid    = hsel && htrans[1] && hready;
    assign wr_commit   = dp_wr_r && hready;
    assign clr_cnt     = wr_commit && (dp_addr_r == mm_port_pkg::OFS_CTRL)
                         && hwdata[mm_port_pkg::CTRL_CLR_BIT];
    assign hreadyout   = !(dp_rd_r && !rd_done_r);
    assign hrdata      = hrdata_r;
    assign hresp       = 1'b0;

    assign status_word = (32'(tag_count) << mm_port_pkg::STAT_TAGS_LSB)
                       | (32'(in_burst) << mm_port_pkg::STAT_WBURST_BIT)
                       | (32'(cmd_valid_r && stall) << mm_port_pkg::STAT_STALL_BIT)
                       | (32'(cmd_valid_r) << mm_port_pkg::STAT_CMD_BIT);
    assign config_word = (32'(LATENCY[7:0]) << mm_port_pkg::CFG_LAT_LSB)
                       | (32'(MODE) << mm_port_pkg::CFG_MODE_LSB)
                       | (32'(WAITREQ) << mm_port_pkg::CFG_WREQ_BIT)
                       | (32'(ASPACE[7:0]) << mm_port_pkg::CFG_ASPACE_LSB)
                       | 32'(MAXB_EFF);
    assign reg_mux =
        (dp_addr_r == mm_port_pkg::OFS_CTRL)    ? 32'(en_r)       :
        (dp_addr_r == mm_port_pkg::OFS_BASE_LO) ? base_r[31:0]    :
        (dp_addr_r == mm_port_pkg::OFS_BASE_HI) ? base_r[63:32]   :
        (dp_addr_r == mm_port_pkg::OFS_STATUS)  ? status_word     :
        (dp_addr_r == mm_port_pkg::OFS_RDCNT)   ? rd_cnt_r        :
        (dp_addr_r == mm_port_pkg::OFS_WRCNT)   ? wr_cnt_r        :
        (dp_addr_r == mm_port_pkg::OFS_CONFIG)  ? config_word     : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_rd_r   <= 1'b0;
            dp_wr_r   <= 1'b0;
            rd_done_r <= 1'b0;
            dp_addr_r <= '0;
            hrdata_r  <= 32'h0000_0000;
        end else begin
            if (hready) begin
                dp_rd_r   <= ap_valid && !hwrite;
                dp_wr_r   <= ap_valid && hwrite;
                dp_addr_r <= haddr[mm_port_pkg::OFS_W-1:0];
                rd_done_r <= 1'b0;
            end else begin
                rd_done_r <= 1'b1;
            end
            if (dp_rd_r && !rd_done_r) begin
                hrdata_r <= reg_mux;
            end
        end
    end

    // counters: an issue in the clearing cycle is still counted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_r     <= mm_port_pkg::CTRL_EN_RST;
            base_r   <= mm_port_pkg::BASE_RST;
            rd_cnt_r <= 32'h0000_0000;
            wr_cnt_r <= 32'h0000_0000;
        end else begin
            if (wr_commit && dp_addr_r == mm_port_pkg::OFS_CTRL) begin
                en_r <= hwdata[mm_port_pkg::CTRL_EN_BIT];
            end
            if (wr_commit && dp_addr_r == mm_port_pkg::OFS_BASE_LO) begin
                base_r[31:0] <= hwdata;
            end
            if (wr_commit && dp_addr_r == mm_port_pkg::OFS_BASE_HI) begin
                base_r[63:32] <= hwdata;
            end
            rd_cnt_r <= (clr_cnt ? 32'h0000_0000 : rd_cnt_r) + 32'(issue && !cmd_wr_r);
            wr_cnt_r <= (clr_cnt ? 32'h0000_0000 : wr_cnt_r) + 32'(issue && cmd_wr_r);
        end
    end

    // ****************************************
    // site arbitration and address forming
    // ****************************************
    mm_site_arbiter #(
        .N    (SITES),
        .IDXW (IDXW)
    ) u_arb (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .req       (site_req),
        .hold      (in_burst),
        .taken     (take),
        .grant_idx (sel)
    );

    assign in_burst  = (wbeats_r != '0);
    assign sel_wr    = site_wr[sel];
    assign sel_burst = (MAXB_EFF == 1) ? BCW'(1) : site_burst[sel];
    assign addr_full = base_r + site_offset[sel];
    assign stall     = WAITREQ && mm_waitrequest;
    // a burst continuation only takes further write beats from the held site
    assign sel_ok    = CFG_OK && site_req[sel] &&
                       (in_burst ? sel_wr : en_r && (sel_wr ? CAN_WR : CAN_RD && !tag_full));
    assign take      = sel_ok && (!cmd_valid_r || !stall);
    assign issue     = cmd_valid_r && !stall;

    for (genvar g = 0; g < SITES; g++) begin : g_gnt
        assign site_gnt[g] = take && (sel == IDXW'(g));
    end

    // lanes outside the aligned group of the access are never merged in
    for (genvar g = 0; g < BEW; g++) begin : g_coal
        if (ALIGN >= BEW) begin : g_all
            assign coal_mask[g] = 1'b1;
        end else begin : g_grp
            assign coal_mask[g] = ((int'(addr_full[$clog2(BEW)-1:0]) / ALIGN) == (g / ALIGN));
        end
    end

    // ****************************************
    // command stage
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_valid_r <= 1'b0;
            cmd_wr_r    <= 1'b0;
            cmd_addr_r  <= '0;
            cmd_be_r    <= '0;
            cmd_data_r  <= '0;
            cmd_burst_r <= '0;
            wbeats_r    <= '0;
        end else if (take) begin
            cmd_valid_r <= 1'b1;
            cmd_be_r    <= site_be[sel] & coal_mask;
            cmd_data_r  <= site_wdata[sel];
            if (!in_burst) begin
                cmd_wr_r    <= sel_wr;
                cmd_addr_r  <= addr_full[AWIDTH-1:0] & WORD_MASK;
                cmd_burst_r <= sel_burst;
                wbeats_r    <= sel_wr ? sel_burst - 1'b1 : '0;
            end else begin
                wbeats_r    <= wbeats_r - 1'b1;
            end
        end else if (issue) begin
            cmd_valid_r <= 1'b0;
        end
    end

    assign mm_address    = cmd_addr_r;
    assign mm_read       = CAN_RD && cmd_valid_r && !cmd_wr_r;
    assign mm_write      = CAN_WR && cmd_valid_r && cmd_wr_r;
    assign mm_writedata  = CAN_WR ? cmd_data_r : '0;
    assign mm_byteenable = cmd_be_r;
    assign mm_burstcount = cmd_burst_r;

    // ****************************************
    // read return, in issue order
    // ****************************************
    // tag is pushed when the read enters the command stage, a cycle
    // ahead of issue, so the head register is ready for the first beat
    mm_tag_fifo #(
        .W     (TW),
        .DEPTH (TAG_DEPTH),
        .CW    (TCW)
    ) u_tags (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .push      (take && !in_burst && !sel_wr),
        .push_data ({sel, sel_burst}),
        .pop       (beat_valid && beat_last),
        .head_r    (tag_head),
        .count_r   (tag_count),
        .full      (tag_full)
    );

    // fixed latency: data is valid exactly LATENCY cycles after issue
    assign beat_valid = (LATENCY == 0) ? mm_readdatavalid : lat_pipe_r[LP-1];
    assign beat_last  = (rbeat_r + 1'b1 == tag_head[BCW-1:0]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lat_pipe_r  <= '0;
            rbeat_r     <= '0;
            rsp_valid_r <= 1'b0;
            rsp_site_r  <= '0;
            rsp_last_r  <= 1'b0;
            rsp_data_r  <= '0;
        end else begin
            lat_pipe_r  <= LP'({lat_pipe_r, issue && !cmd_wr_r});
            rsp_valid_r <= beat_valid;
            if (beat_valid) begin
                rbeat_r    <= beat_last ? '0 : rbeat_r + 1'b1;
                rsp_site_r <= tag_head[TW-1:BCW];
                rsp_last_r <= beat_last;
                rsp_data_r <= mm_readdata;
            end
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_site  = rsp_site_r;
    assign rsp_last  = rsp_last_r;
    assign rsp_data  = rsp_data_r;
endmodule

// >>> src/mm_port_pkg.sv
// Purpose: shared constants for the memory bus pointer port
// Assumes: one aligned 32-bit word per control register
// Notes:   offsets are byte addresses on the control bus
package mm_port_pkg;

    // ****************************************
    // build-time defaults
    // ****************************************
    localparam int DWIDTH_DEF    = 64;
    localparam int AWIDTH_DEF    = 64;
    localparam int PTR_W         = 64;
    localparam int ASPACE_DEF    = 1;
    localparam int LATENCY_DEF   = 1;
    localparam int MAXBURST_DEF  = 1;
    localparam int MAXBURST_MAX  = 1024;
    localparam int SITES_DEF     = 2;
    localparam int TAG_DEPTH_DEF = 8;

    typedef enum logic [1:0] {
        MODE_READWRITE,
        MODE_READONLY,
        MODE_WRITEONLY
    } rw_mode_t;

    // ****************************************
    // control register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_BASE_LO = 8'h04;
    localparam logic [7:0] OFS_BASE_HI = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_RDCNT   = 8'h10;
    localparam logic [7:0] OFS_WRCNT   = 8'h14;
    localparam logic [7:0] OFS_CONFIG  = 8'h18;
    localparam int         OFS_W       = 8;

    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_CLR_BIT    = 1;
    localparam int STAT_CMD_BIT    = 0;
    localparam int STAT_STALL_BIT  = 1;
    localparam int STAT_WBURST_BIT = 2;
    localparam int STAT_TAGS_LSB   = 8;
    localparam int CFG_LAT_LSB     = 24;
    localparam int CFG_MODE_LSB    = 22;
    localparam int CFG_WREQ_BIT    = 21;
    localparam int CFG_ASPACE_LSB  = 12;

    localparam logic        CTRL_EN_RST = 1'b0;
    localparam logic [63:0] BASE_RST    = 64'h0;

endpackage

// >>> src/mm_site_arbiter.sv
// Purpose: round-robin choice among access sites of one address space
// Assumes: requests come from logic on the same clock
// Notes:   hold freezes the choice, used while a write burst streams
`timescale 1ns/1ns
module mm_site_arbiter #(
    parameter int N    = 2,
    parameter int IDXW = (N > 1) ? $clog2(N) : 1
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic [N-1:0]    req,
    input  wire logic            hold,
    input  wire logic            taken,
    output logic      [IDXW-1:0] grant_idx
);
    logic [IDXW-1:0] last_r;
    logic [IDXW-1:0] pick;

    // search starts after the last winner so no site starves
    always_comb begin
        logic [IDXW-1:0] cand;
        pick = last_r;
        cand = last_r;
        for (int k = 1; k <= N; k++) begin
            cand = IDXW'((int'(last_r) + N + 1 - k) % N);
            if (req[cand]) begin
                pick = cand;
            end
        end
    end

    assign grant_idx = hold ? last_r : pick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_r <= '0;
        end else if (taken) begin
            last_r <= grant_idx;
        end
    end
endmodule

// >>> src/mm_tag_fifo.sv
// Purpose: in-order record of outstanding reads
// Assumes: an entry is pushed at least two edges before it is needed
// Notes:   head word comes out of a register
`timescale 1ns/1ns
module mm_tag_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          push,
    input  wire logic [W-1:0]  push_data,
    input  wire logic          pop,
    output logic      [W-1:0]  head_r,
    output logic      [CW-1:0] count_r,
    output logic               full
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW-1:0] rd_ptr_nxt;

    assign full       = (count_r == CW'(DEPTH));
    assign rd_ptr_nxt = !pop ? rd_ptr_r :
                        (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            head_r   <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_r + CW'(push) - CW'(pop);
            head_r   <= mem[rd_ptr_nxt];
        end
    end
endmodule

// >>> dv/mm_port_monitor.sv
// Purpose: concurrent checks on the memory bus pointer port
// Assumes: one clock domain, hresetn active low
// Notes:   bound to every instance of the port
`timescale 1ns/1ns
module mm_port_monitor #(
    parameter int DWIDTH  = 64,
    parameter int AWIDTH  = 64,
    parameter int LATENCY = 1,
    parameter int SITES   = 2,
    parameter int BCW     = 1,
    parameter bit WAITREQ = 1'b0
) (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic [SITES-1:0]    site_gnt,
    input wire logic                rsp_valid,
    input wire logic [AWIDTH-1:0]   mm_address,
    input wire logic                mm_read,
    input wire logic                mm_write,
    input wire logic [DWIDTH-1:0]   mm_writedata,
    input wire logic [DWIDTH/8-1:0] mm_byteenable,
    input wire logic [BCW-1:0]      mm_burstcount,
    input wire logic                mm_waitrequest
);
    // ********
    // checks
    // ********
    localparam int RSP_DLY = LATENCY + 1;
    logic rd_take;
    assign rd_take = mm_read && !(WAITREQ && mm_waitrequest);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_stalled;
        WAITREQ && (mm_read || mm_write) && mm_waitrequest;
    endsequence
    a_cmd_held: assert property (s_stalled |=> $stable(mm_address) &&
        $stable(mm_read) && $stable(mm_write) && $stable(mm_writedata) &&
        $stable(mm_byteenable) && $stable(mm_burstcount)) else $error("command moved in stall");
    a_rsp_fixed: assert property (rd_take && LATENCY != 0 |-> ##RSP_DLY rsp_valid)
        else $error("read data late");
    a_rsp_cause: assert property (rsp_valid && LATENCY != 0 |-> $past(rd_take, RSP_DLY))
        else $error("read data without command");
    a_burst_one: assert property ((mm_read || mm_write) && LATENCY != 0
        |-> mm_burstcount == 1) else $error("burst above one at fixed latency");
    a_addr_word: assert property ((mm_read || mm_write)
        |-> mm_address % (DWIDTH / 8) == 0) else $error("address not word aligned");
    a_gnt_single: assert property ($onehot0(site_gnt)) else $error("two grants");
    a_gnt_issue: assert property (site_gnt != 0 |=> mm_read || mm_write)
        else $error("grant without command");
    a_dir_excl: assert property (!(mm_read && mm_write)) else $error("read and write");
endmodule
bind memory_bus_pointer_port mm_port_monitor #(.DWIDTH(DWIDTH), .AWIDTH(AWIDTH),
    .LATENCY(LATENCY), .SITES(SITES), .BCW(BCW), .WAITREQ(WAITREQ)) u_mon (.hclk, .hresetn,
    .site_gnt, .rsp_valid, .mm_address, .mm_read, .mm_write, .mm_writedata, .mm_byteenable,
    .mm_burstcount, .mm_waitrequest);

// >>> dv/mm_slave_model.sv
// Purpose: memory slave on the far side of the port
// Assumes: fixed read latency of one cycle
// Notes:   slow stalls every other cycle through waitrequest
`timescale 1ns/1ns
module mm_slave_model #(
    parameter int DW = 64
) (
    input  wire logic           hclk,
    input  wire logic           slow,
    input  wire logic [63:0]    mm_address,
    input  wire logic           mm_read,
    input  wire logic           mm_write,
    input  wire logic [DW-1:0]  mm_writedata,
    input  wire logic [DW/8-1:0] mm_byteenable,
    output logic      [DW-1:0]  mm_readdata = '0,
    output logic                mm_readdatavalid = 1'b0,
    output logic                mm_waitrequest
);
    logic [DW-1:0] mem [bit [63:0]];
    logic [DW-1:0] word;
    logic          tog = 1'b0;
    assign mm_waitrequest = slow & tog;
    always @(posedge hclk) begin
        tog <= ~tog;
        mm_readdatavalid <= 1'b0;
        // bus not driven: flip so stale data never looks valid
        mm_readdata <= ~mm_readdata;
        if ((mm_read || mm_write) && !mm_waitrequest) begin
            word = mem.exists(mm_address) ? mem[mm_address] : '0;
            if (mm_read) begin
                mm_readdata <= word;
                mm_readdatavalid <= 1'b1;
            end else begin
                for (int b = 0; b < DW / 8; b++) begin
                    if (mm_byteenable[b]) word[8*b+:8] = mm_writedata[8*b+:8];
                end
                mem[mm_address] = word;
            end
        end
    end
endmodule

// >>> dv/memory_bus_pointer_port_test.sv
// Purpose: self-checking bench for the memory bus pointer port
// Assumes: defaults, waitrequest on, address space 3
// Notes:   control bus and sites driven from tasks
`timescale 1ns/1ns
module memory_bus_pointer_port_test;
    logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic [1:0]       htrans = 2'h0, site_req = 2'h0, site_wr = 2'h0, site_gnt;
    logic [31:0]      haddr = 32'h0, hwdata = 32'h0, q, hrdata;
    logic [1:0][63:0] site_offset = '0, site_wdata = '0;
    logic [63:0]      base = 64'h1_0000_1000;
    logic             hreadyout, rsp_valid, rsp_site, mm_read, mm_write, mm_rdv, mm_wreq;
    logic             rsp_last;
    logic [7:0]       mm_be;
    logic [0:0]       mm_bc;
    logic [63:0]      rsp_data, mm_address, mm_wdata, mm_rdata;
    int               n_fail = 0, check_count = 0;
    always #20 hclk = ~hclk;
    memory_bus_pointer_port #(.ASPACE(3), .WAITREQ(1'b1)) dut (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hrdata, .hresp(), .site_req, .site_wr, .site_offset, .site_wdata,
        .site_be(16'hffff), .site_burst(2'h3), .site_gnt, .rsp_valid, .rsp_site,
        .rsp_last, .rsp_data, .mm_address, .mm_read, .mm_write, .mm_writedata(mm_wdata),
        .mm_byteenable(mm_be), .mm_burstcount(mm_bc), .mm_readdata(mm_rdata),
        .mm_readdatavalid(mm_rdv), .mm_waitrequest(mm_wreq));
    mm_slave_model u_slave (.hclk, .slow, .mm_address, .mm_read, .mm_write,
        .mm_writedata(mm_wdata), .mm_byteenable(mm_be), .mm_readdata(mm_rdata),
        .mm_readdatavalid(mm_rdv), .mm_waitrequest(mm_wreq));
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic site(input int s, input logic wr, input logic [63:0] off, d);
        site_req[s] <= 1'b1;
        site_wr[s] <= wr;
        site_offset[s] <= off;
        site_wdata[s] <= d;
        do @(posedge hclk); while (site_gnt[s] !== 1'b1);
        site_req[s] <= 1'b0;
        @(posedge hclk);
        check("mm_address", base + off, mm_address);
        check("mm_burstcount", 64'h1, 64'(mm_bc));
        check("mm_byteenable", 64'hff, 64'(mm_be));
        if (!wr) begin
            do @(posedge hclk); while (rsp_valid !== 1'b1);
            check("rsp_data", d, rsp_data);
            check("rsp_last", 64'h1, 64'(rsp_last));
            check("rsp_site", 64'(s), 64'(rsp_site));
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            if (i != 3 && i != 6) begin
                ahb(1'b0, 8'(4 * i), 32'h0);
                check("reset value", 64'h0, 64'(q));
            end
        end
        ahb(1'b0, mm_port_pkg::OFS_CONFIG, 32'h0);
        check("config", 64'h0120_3001, 64'(q));
        ahb(1'b1, 8'h1c, 32'hffff_ffff);
        ahb(1'b0, 8'h1c, 32'h0);
        check("unmapped", 64'h0, 64'(q));
        ahb(1'b1, mm_port_pkg::OFS_BASE_LO, base[31:0]);
        ahb(1'b1, mm_port_pkg::OFS_BASE_HI, base[63:32]);
        ahb(1'b1, mm_port_pkg::OFS_CTRL, 32'h1);
        site(0, 1'b1, 64'h8, 64'h0123_4567_89ab_cdef);
        site(1, 1'b1, 64'h10, 64'hfedc_ba98_7654_3210);
        slow <= 1'b1;
        site(1, 1'b0, 64'h8, 64'h0123_4567_89ab_cdef);
        site(0, 1'b0, 64'h10, 64'hfedc_ba98_7654_3210);
        ahb(1'b0, mm_port_pkg::OFS_WRCNT, 32'h0);
        check("write count", 64'h2, 64'(q));
        ahb(1'b0, mm_port_pkg::OFS_RDCNT, 32'h0);
        check("read count", 64'h2, 64'(q));
        final_report();
    end
endmodule
